// ### rtl/gbci_initiator.sv
// Guard break cycle initiator: start sequencing for a press
// Notes on behaviour
// - Breaks-first order: breaks then rearm
// - Rearm-first order: rearm then breaks
// - Four causes force a full start
// - Stray break restart without rearm when allowed
// - Breaks shorter than minimum ignored
// - Start release needed for full start
// - Stroke-end rising edge clears break counter
// - Later strokes start after counted breaks
// - Guard timeout flags and forces full start
// - Guard timer starts at stroke-end rising edge
// - Guard limit default 30 s, 0 disables
// - After-upstroke: break falls after upstroke rise
// - After-stroke-end: break falls after marker rise
// - Break end must follow marker rise
// - No muting: guard fall drops enable
// - Muting active only if time nonzero
// - Muting bypasses guard on upstroke, marker low
// - Upstroke rise restarts muting timer
// - Only-top: start only at top
// - Stop by release or guard needs stroke end
// - Static release low forces enable low
// - Rearm pulse width between minimum and 30 s
// - Unexpected guard fall sets stray flag
`timescale 1ns/1ps
`include "gbci_cfg.svh"
module gbci_initiator import gbci_pkg::*; #(
  parameter int TICK_DIV = `GBCI_TICK_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire gbci_cfg_s cfg,
  input wire logic staticRelease,
  input wire logic startRelease,
  input wire logic guardBreakInput,
  input wire logic strokeEnd,
  input wire logic upstroke,
  input wire logic rearm,
  input wire logic driveCommandLoopback,
  output logic enable,
  output gbci_diag_s diag
);
  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 32'(TICK_DIV - 1));
      div_q <= (div_q == 32'(TICK_DIV - 1)) ? 32'h0 : div_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Three-stage pin synchronisers, change accepted when stages two and three agree
  localparam int NIN = 6;
  wire [NIN-1:0] pinRaw = {staticRelease, startRelease, guardBreakInput, strokeEnd,
                           upstroke, rearm};
  logic [NIN-1:0] s1_q, s2_q, s3_q, clean_q;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          clean_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pinRaw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) clean_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate
  wire relS = clean_q[5];
  wire startS = clean_q[4];
  wire guardS = clean_q[3];
  wire topS = clean_q[2];
  wire upS = clean_q[1];
  wire rearmS = clean_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection on cleaned inputs and loopback
  logic guardD_q, topD_q, upD_q, driveD_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      guardD_q <= 1'b0; // Matches the cleared synchroniser, no false fall after reset
      topD_q <= 1'b0;
      upD_q <= 1'b0;
      driveD_q <= 1'b0;
    end else begin
      guardD_q <= guardS;
      topD_q <= topS;
      upD_q <= upS;
      driveD_q <= driveCommandLoopback;
    end
  end
  wire guardFall = guardD_q & ~guardS;
  wire topRise = topS & ~topD_q;
  wire upRise = upS & ~upD_q;
  wire driveOn = driveCommandLoopback & ~driveD_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse meters for breaks (guard low) and rearm (high)
  wire [15:0] breakMin = cfg.longBreak ? 16'(`GBCI_MS_LONG) : 16'(`GBCI_MS_SHORT);
  wire [15:0] rearmMin = cfg.longRearm ? 16'(`GBCI_MS_LONG) : 16'(`GBCI_MS_SHORT);
  logic breakEnd, rearmOk;
  gbci_pulse_timer u_break (
    .clk(clk), .sys_rst(sys_rst), .tick(tick_q), .level(~guardS),
    .minMs(breakMin), .maxMs(16'hFFFF), .validEnd(breakEnd)
  );
  gbci_pulse_timer u_rearm (
    .clk(clk), .sys_rst(sys_rst), .tick(tick_q), .level(rearmS),
    .minMs(rearmMin), .maxMs(16'(`GBCI_REARM_MAX_MS)), .validEnd(rearmOk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Upstroke muting timer in milliseconds
  logic [23:0] muteCnt_q;
  logic muteRun_q;
  wire muteOn = (cfg.muteSec != 13'h0);
  wire [23:0] muteLim = 24'(cfg.muteSec) * 24'h0003E8;
  wire muting = muteOn & muteRun_q & upS & ~topS;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      muteCnt_q <= 24'h0;
      muteRun_q <= 1'b0;
    end else if (upRise && muteOn) begin
      muteCnt_q <= 24'h0;
      muteRun_q <= 1'b1;
    end else if (muteRun_q && tick_q) begin
      if (muteCnt_q + 24'h1 >= muteLim) muteRun_q <= 1'b0;
      muteCnt_q <= muteCnt_q + 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Break window qualification
  logic armed_q, inBreak_q, breakOk_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed_q <= 1'b1;
      inBreak_q <= 1'b0;
      breakOk_q <= 1'b0;
    end else begin
      if (topRise || (cfg.afterUpstroke && upRise)) armed_q <= 1'b1;
      else if (enable) armed_q <= 1'b0;
      if (guardFall) begin
        inBreak_q <= armed_q;
        breakOk_q <= cfg.afterUpstroke ? 1'b0 : 1'b1;
      end
      if (topRise || topS) breakOk_q <= 1'b1;
    end
  end
  wire countBreak = breakEnd & inBreak_q & (breakOk_q | topS);

  ////////////////////////////////////////////////////////////////////////////////
  // Guard time monitor
  logic [19:0] guardCnt_q;
  logic guardRun_q;
  wire guardOn = (cfg.guardSec != 9'h0);
  wire [19:0] guardLim = 20'(cfg.guardSec) * 20'h003E8;
  wire guardExpire = guardOn & guardRun_q & tick_q & (guardCnt_q + 20'h1 >= guardLim);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence state
  gbci_state_e st_q, st_d;
  logic [3:0] breaks_q;
  logic rearmDone_q, firstDone_q;
  wire breaksDone = (breaks_q >= cfg.breakCount);
  wire startNeed = (cfg.startCond == `GBCI_START_EVERY) ||
                   (cfg.startCond == `GBCI_START_FIRST && !firstDone_q);
  wire startOk = !startNeed || startS;
  wire posOk = !cfg.onlyTop || topS;
  wire fullDone = cfg.rearmFirst ? (rearmDone_q && breaksDone)
                                 : (breaksDone && rearmOk);
  wire strayShortcut = diag.strayBreakFlag && !enable && !guardS &&
    (cfg.lockMode == `GBCI_LOCK_NONE ||
     (cfg.lockMode == `GBCI_LOCK_ALWAYS && upS));
  wire guardLost = !guardS && !muting && !(cfg.lockMode == `GBCI_LOCK_UPSTROKE && upS);
  // A fall is stray only in ST_RUN, with the break window disarmed and the guard not muted
  wire stray = guardFall && !muting && st_q == ST_RUN && !armed_q;
  wire fullCause = !relS || guardExpire || driveOn ||
                   (stray && breaks_q == 4'h0 && !muting && !topS);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_FULL: if (relS && posOk && startOk && (fullDone || strayShortcut)) st_d = ST_RUN;
      ST_CYCLE: if (relS && posOk && startOk && breaksDone) st_d = ST_RUN;
      ST_RUN: begin
        if (fullCause) st_d = ST_FULL;
        else if (guardLost) st_d = ST_STOP;
        else if (topRise) st_d = ST_CYCLE;
      end
      ST_STOP: if (topRise) st_d = ST_FULL;
      default: st_d = ST_FULL;
    endcase
    if (!relS) st_d = ST_FULL;
    if (guardExpire && st_q != ST_RUN) st_d = ST_FULL;
  end

  // State, counters and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_FULL;
      breaks_q <= 4'h0;
      rearmDone_q <= 1'b0;
      firstDone_q <= 1'b0;
      guardCnt_q <= 20'h0;
      guardRun_q <= 1'b0;
      enable <= 1'b0;
      diag <= '0;
    end else begin
      st_q <= st_d;
      enable <= (st_d == ST_RUN) && relS;
      if (st_d == ST_RUN) begin
        breaks_q <= 4'h0;
        rearmDone_q <= 1'b0;
      end else begin
        if (topRise) breaks_q <= 4'h0;
        else if (countBreak && !breaksDone &&
                 (!cfg.rearmFirst || rearmDone_q || st_q == ST_CYCLE)) breaks_q <= breaks_q + 4'h1;
        if (rearmOk) rearmDone_q <= 1'b1;
      end
      if (st_q == ST_FULL && st_d == ST_RUN) firstDone_q <= 1'b1;
      // Guard timer: starts at stroke end with all stop conditions met
      if (topRise && relS && st_d != ST_RUN) begin
        guardRun_q <= 1'b1;
        guardCnt_q <= 20'h0;
      end else if (st_d == ST_RUN || guardExpire) begin
        guardRun_q <= 1'b0;
      end else if (guardRun_q && tick_q) begin
        guardCnt_q <= guardCnt_q + 20'h1;
      end
      if (guardExpire) diag.guardTimeExpired <= 1'b1;
      else if (rearmOk) diag.guardTimeExpired <= 1'b0;
      if (stray) diag.strayBreakFlag <= 1'b1;
      else if (st_d == ST_RUN) diag.strayBreakFlag <= 1'b0;
      if (st_q == ST_RUN && (!relS || guardLost)) diag.strokeEndRequired <= 1'b1;
      else if (topRise) diag.strokeEndRequired <= 1'b0;
      diag.rearmRequired <= (st_d == ST_FULL) &&
        (cfg.rearmFirst ? !rearmDone_q : breaksDone);
      diag.breakRequired <= (st_d == ST_CYCLE) ||
        (st_d == ST_FULL && !breaksDone && (!cfg.rearmFirst || rearmDone_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  release_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    !relS |=> !enable) else $error("enable high after release low");
  expire_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    guardExpire |=> diag.guardTimeExpired && !enable) else $error("timeout not flagged");
  guard_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !guardOn |-> !guardExpire) else $error("guard timer ran while disabled");
  mute_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !muteOn |-> !muting) else $error("muting while disabled");
  top_only_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(enable) && cfg.onlyTop |-> $past(topS)) else $error("start off top");
  stray_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    stray |=> diag.strayBreakFlag) else $error("stray flag missed");
  top_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    topRise && st_d != ST_RUN |=> breaks_q == 4'h0) else $error("counter not cleared");
  start_rel_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(enable) && startNeed |-> $past(startS)) else $error("start release missing");
endmodule // gbci_initiator

// ### include/gbci_cfg.svh
// Timing counts and settings codes for the guard break cycle initiator
`ifndef GBCI_CFG_SVH
`define GBCI_CFG_SVH
`define GBCI_CLK_HZ 25000000
`define GBCI_TICK_HZ 1000
`define GBCI_TICK_DIV (`GBCI_CLK_HZ / `GBCI_TICK_HZ)
`define GBCI_MS_SHORT 100
`define GBCI_MS_LONG 350
`define GBCI_REARM_MAX_MS 30000
`define GBCI_GUARD_DEF_S 30
`define GBCI_START_NONE 2'h0
`define GBCI_START_FIRST 2'h1
`define GBCI_START_EVERY 2'h2
`define GBCI_LOCK_ALWAYS 2'h0
`define GBCI_LOCK_UPSTROKE 2'h1
`define GBCI_LOCK_NONE 2'h2
`endif

// ### include/gbci_pkg.sv
// Types shared by the guard break cycle initiator
package gbci_pkg;
  typedef struct packed {
    logic [3:0] breakCount;   // 1 to 8
    logic rearmFirst;         // 0: breaks first, 1: rearm first
    logic [12:0] muteSec;     // 0 disables muting
    logic [8:0] guardSec;     // 0 disables guard timer
    logic [1:0] startCond;
    logic afterUpstroke;      // first-break timing
    logic [1:0] lockMode;
    logic longRearm;          // 350 ms minimum rearm
    logic onlyTop;
    logic longBreak;          // 350 ms minimum break
  } gbci_cfg_s;
  typedef struct packed {
    logic strayBreakFlag;
    logic guardTimeExpired;
    logic strokeEndRequired;
    logic rearmRequired;
    logic breakRequired;
  } gbci_diag_s;
  typedef enum logic [3:0] {
    ST_FULL = 4'b0001,
    ST_CYCLE = 4'b0010,
    ST_RUN = 4'b0100,
    ST_STOP = 4'b1000
  } gbci_state_e;
endpackage

// ### rtl/gbci_pulse_timer.sv
// High pulse width meter on millisecond ticks
`timescale 1ns/1ps
module gbci_pulse_timer import gbci_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic level,
  input wire logic [15:0] minMs,
  input wire logic [15:0] maxMs,
  output logic validEnd
);
  logic [15:0] cnt_q;
  logic level_q;
  wire rise = level & ~level_q;
  wire widthOk = (cnt_q >= minMs) && (cnt_q <= maxMs);
  // Count while level high, judge width at its falling edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      level_q <= 1'b0;
      validEnd <= 1'b0;
    end else begin
      level_q <= level;
      validEnd <= level_q & ~level & widthOk;
      if (rise) cnt_q <= 16'h0000;
      else if (level && tick && cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // gbci_pulse_timer

// ### test/gbci_press_model.sv
// Press cam contact and light curtain model for the initiator's far side
`timescale 1ns/1ps
module gbci_press_model import gbci_pkg::*; #(
  parameter int MS = 10
) (
  clk,
  guardBreakInput,
  strokeEnd,
  upstroke,
  driveCommandLoopback
);
  input wire logic clk;
  output logic guardBreakInput;
  output logic strokeEnd;
  output logic upstroke;
  output logic driveCommandLoopback;
  ////////////////////////////////////////////////////////////////////////////////
  // Drive command is an internal level that is already on, so it never rises
  assign driveCommandLoopback = 1'b1;
  // Curtain clear and press away from top at power up
  initial begin
    guardBreakInput = 1'b1;
    strokeEnd = 1'b0;
    upstroke = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Wait whole cycles, then step just past the edge
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One interruption of the curtain, low for the given milliseconds
  task automatic breakGuard(input int ms);
    guardBreakInput = 1'b0;
    waitCyc(ms * MS);
    guardBreakInput = 1'b1;
    waitCyc(50);
  endtask
  // One stroke: leave top, upstroke, arrive back at top
  task automatic stroke();
    strokeEnd = 1'b0;
    waitCyc(100);
    upstroke = 1'b1;
    waitCyc(100);
    upstroke = 1'b0;
    waitCyc(50);
    strokeEnd = 1'b1;
    waitCyc(100);
  endtask
endmodule // gbci_press_model

// ### test/tb_top.sv
// Self-checking bench for the guard break cycle initiator
`timescale 1ns/1ps
`include "gbci_cfg.svh"
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin nMismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top import gbci_pkg::*; ;
  localparam int MS = 10;
  typedef struct packed {
    logic rf;
    logic lb;
    logic [3:0] cnt;
    logic sr;
    logic [8:0] ms;
    logic en;
  } gbci_row_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  gbci_cfg_s cfg;
  logic staticRelease;
  logic startRelease;
  logic rearm;
  logic enable;
  logic guardBreakInput;
  logic strokeEnd;
  logic upstroke;
  logic driveCommandLoopback;
  gbci_diag_s diag;
  int nMismatch = 0;
  int totalChecks = 0;
  // Order, break width, break count and start release cases with the enable they give
  gbci_row_s rows [6] = '{
    '{1'b0, 1'b0, 4'h1, 1'b1, 9'h096, 1'b1},
    '{1'b1, 1'b0, 4'h1, 1'b1, 9'h096, 1'b1},
    '{1'b0, 1'b1, 4'h1, 1'b1, 9'h0C8, 1'b0},
    '{1'b0, 1'b1, 4'h1, 1'b1, 9'h190, 1'b1},
    '{1'b0, 1'b0, 4'h2, 1'b1, 9'h096, 1'b0},
    '{1'b0, 1'b0, 4'h1, 1'b0, 9'h096, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and press model
  always #20 clk = ~clk;
  gbci_initiator #(.TICK_DIV(MS)) i_dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .staticRelease(staticRelease), .startRelease(startRelease),
    .guardBreakInput(guardBreakInput), .strokeEnd(strokeEnd), .upstroke(upstroke),
    .rearm(rearm), .driveCommandLoopback(driveCommandLoopback), .enable(enable), .diag(diag));
  gbci_press_model #(.MS(MS)) i_press (.clk(clk), .guardBreakInput(guardBreakInput),
    .strokeEnd(strokeEnd), .upstroke(upstroke), .driveCommandLoopback(driveCommandLoopback));
  ////////////////////////////////////////////////////////////////////////////////
  // Bench tasks
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic doReset(input logic rf, input logic lb, input logic [3:0] cnt,
                         input logic sr, input logic [8:0] gs);
    cfg = '{breakCount: cnt, rearmFirst: rf, muteSec: 13'h0000, guardSec: gs,
            startCond: `GBCI_START_EVERY, afterUpstroke: 1'b0, lockMode: `GBCI_LOCK_ALWAYS,
            longRearm: 1'b0, onlyTop: 1'b0, longBreak: lb};
    staticRelease = 1'b1;
    startRelease = sr;
    rearm = 1'b0;
    sys_rst = 1'b1;
    waitCyc(6);
    `CHK("enable in reset", 1'b0, enable)
    `CHK("diag in reset", 5'h00, diag)
    sys_rst = 1'b0;
    i_press.stroke();
  endtask
  // Low-high-low on the rearm input, high for the given milliseconds
  task automatic rearmPulse(input int ms);
    rearm = 1'b1;
    waitCyc(ms * MS);
    rearm = 1'b0;
    waitCyc(50);
  endtask
  task automatic fullStart(input logic rf, input int n, input int ms);
    if (rf) rearmPulse(150);
    repeat (n) i_press.breakGuard(ms);
    if (!rf) rearmPulse(150);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung sequence
  initial begin
    waitCyc(90000);
    nMismatch++;
    wrap_up();
  end
  // Table cases, then timeout, cycle start and release drop
  initial begin
    for (int i = 0; i < 6; i++) begin
      doReset(rows[i].rf, rows[i].lb, rows[i].cnt, rows[i].sr, 9'h01E);
      fullStart(rows[i].rf, 1, int'(rows[i].ms));
      `CHK("enable after full start", rows[i].en, enable)
      $display("row %0d done", i);
    end
    doReset(1'b0, 1'b0, 4'h1, 1'b1, 9'h001);
    fullStart(1'b0, 1, 150);
    `CHK("enable before stroke", 1'b1, enable)
    i_press.stroke();
    waitCyc(8900);
    `CHK("timeout early", 1'b0, diag.guardTimeExpired)
    waitCyc(1600);
    `CHK("timeout flag", 1'b1, diag.guardTimeExpired)
    `CHK("enable at timeout", 1'b0, enable)
    i_press.breakGuard(150);
    `CHK("enable needs full start", 1'b0, enable)
    `CHK("rearm required", 1'b1, diag.rearmRequired)
    $display("timeout test done");
    doReset(1'b0, 1'b0, 4'h2, 1'b1, 9'h01E);
    fullStart(1'b0, 2, 150);
    i_press.stroke();
    `CHK("break required", 1'b1, diag.breakRequired)
    i_press.breakGuard(150);
    `CHK("enable after one break", 1'b0, enable)
    i_press.breakGuard(150);
    `CHK("enable after cycle start", 1'b1, enable)
    staticRelease = 1'b0;
    waitCyc(8);
    `CHK("enable on release low", 1'b0, enable)
    `CHK("stroke end required", 1'b1, diag.strokeEndRequired)
    // Restart, then an unexpected curtain break while running
    staticRelease = 1'b1;
    i_press.stroke();
    fullStart(1'b0, 2, 150);
    `CHK("enable after restart", 1'b1, enable)
    i_press.breakGuard(150);
    `CHK("stray flag", 1'b1, diag.strayBreakFlag)
    `CHK("enable on stray break", 1'b0, enable)
    $display("cycle start test done");
    wrap_up();
  end
endmodule // tb_top
